//--- hdl/rsc_recorder.v
`include "rsc_defines.vh"

module rsc_recorder #(
    parameter [31:0] HIST_TICKS = `RSC_HIST_CYC,
    parameter [7:0] HYST = `RSC_HYST_CODES
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [7:0] vin_sample,
    input wire [7:0] vout_sample,
    input wire ramp_busy,
    input wire ramp_ok,
    input wire [15:0] status_word_in,
    input wire [15:0] nv_snap_count,
    input wire primary_on_off_pin,
    input wire ctrl_pin,
    output reg conv_on,
    output reg ctrl_pullup_en,
    output reg snapshot_store,
    output reg [15:0] snap_count,
    output reg [7:0] vendor_status_byte
);

    localparam [3:0] ST_WAIT = 4'h1;
    localparam [3:0] ST_RAMP = 4'h2;
    localparam [3:0] ST_HIST = 4'h4;
    localparam [3:0] ST_DONE = 4'h8;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i])
                    merge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    endfunction

    // off threshold forced at least HYST codes below the on threshold, or to zero when the on threshold is HYST or less
    function [31:0] clamp_cfg;
        input [31:0] c;
        reg [7:0] lim;
        begin
            clamp_cfg = c;
            lim = (c[7:0] > HYST) ? c[7:0] - HYST : 8'h00;
            if (c[15:8] > lim)
                clamp_cfg[15:8] = lim; // see R14
        end
    endfunction

    // shared by the run flag and the snapshot trigger, so both agree on the edge
    function below_off;
        input [7:0] v;
        input [7:0] thr;
        begin
            below_off = v < thr;
        end
    endfunction

    reg [7:0] ramp_mem [0:`RSC_REC_BYTES-1];
    reg [15:0] hist_mem [0:`RSC_HIST_WORDS-1];
    reg [31:0] cfg;
    reg [15:0] ramp_cfg;
    // user area is nonvolatile: factory preload, untouched by reset
    reg [31:0] user_cfg = `RSC_CFG_DEFAULT; // see R11
    reg [15:0] user_ramp = `RSC_RAMP_DEFAULT;
    reg init_done;
    reg [31:0] tick;
    reg [31:0] due;
    reg [3:0] state;
    reg [4:0] idx;
    reg ramp_seen;
    reg ramp_failed;
    reg busy_d;
    reg vin_ok;
    reg aw_full;
    reg w_full;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [31:0] rd_data;
    reg rd_ok;
    reg [31:0] next_cfg;
    reg [31:0] next_ramp;
    reg do_wr;
    integer k;

    // record words: byte 4n lands in bits 7:0
    function [31:0] ramp_word;
        input [2:0] w;
        begin
            ramp_word = {ramp_mem[{w, 2'h3}], ramp_mem[{w, 2'h2}],
                ramp_mem[{w, 2'h1}], ramp_mem[{w, 2'h0}]};
        end
    endfunction

    // history words: even entry in the low half
    function [31:0] hist_word;
        input [2:0] w;
        begin
            hist_word = {hist_mem[{w, 1'b1}], hist_mem[{w, 1'b0}]};
        end
    endfunction

    // idles low like ramp_busy, so no false start after reset
    wire ramp_start = ramp_busy && !busy_d;
    wire ramp_end = !ramp_busy && busy_d;
    wire [15:0] interval = {4'h0, ramp_cfg[15:4]} + 16'h0001; // see R2
    wire pri_on = cfg[`RSC_CFG_PRI_POS] ? primary_on_off_pin : !primary_on_off_pin;
    wire sec_on = !cfg[`RSC_CFG_SEC_EN] ||
        (cfg[`RSC_CFG_SEC_POS] ? ctrl_pin : !ctrl_pin);
    wire [15:0] rec_count = {ramp_mem[0], ramp_mem[1]};
    // writes land only once both channels are held and no response is pending
    wire wr_cfg = do_wr && aw_addr == `RSC_OFS_CFG;
    wire wr_ramp = do_wr && aw_addr == `RSC_OFS_RAMPCFG;
    wire wr_cmd = do_wr && aw_addr == `RSC_OFS_CMD;

    // ----------------------------------------
    // register read decode
    // ----------------------------------------
    always @* begin
        rd_ok = 1'b1;
        rd_data = 32'h0000_0000;
        if (s_axi_araddr[7:5] == 3'h2) begin
            rd_data = ramp_word(s_axi_araddr[4:2]); // see R1
        end else if (s_axi_araddr[7:5] == 3'h3) begin
            rd_data = hist_word(s_axi_araddr[4:2]); // see R8
        end else begin
            case (s_axi_araddr)
                `RSC_OFS_CFG: rd_data = cfg;
                `RSC_OFS_RAMPCFG: rd_data = {16'h0000, ramp_cfg};
                `RSC_OFS_CMD: rd_data = 32'h0000_0000;
                `RSC_OFS_STAT: rd_data = {16'h0000, vendor_status_byte, 3'h0, state, conv_on};
                `RSC_OFS_SNAP: rd_data = {16'h0000, snap_count};
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    always @* begin
        do_wr = aw_full && w_full && !s_axi_bvalid;
        next_cfg = clamp_cfg(merge(cfg, w_data, w_strb));
        next_ramp = merge({16'h0000, ramp_cfg}, w_data, w_strb);
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RSC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RSC_RESP_OKAY;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_full && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_full && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_cfg || wr_ramp || wr_cmd) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full <= 1'b0;
                w_full <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_ok ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // parameter areas and on/off control
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= `RSC_CFG_DEFAULT;
            ramp_cfg <= `RSC_RAMP_DEFAULT;
            init_done <= 1'b0;
            snap_count <= 16'h0000;
            snapshot_store <= 1'b0;
            vin_ok <= 1'b0;
            conv_on <= 1'b0;
            ctrl_pullup_en <= 1'b0;
        end else begin
            snapshot_store <= 1'b0;
            if (!init_done) begin
                init_done <= 1'b1;
                cfg <= user_cfg; // see R13
                ramp_cfg <= user_ramp;
                snap_count <= nv_snap_count;
            end else if (wr_cfg) begin
                cfg <= next_cfg; // see R17, R19
            end else if (wr_ramp) begin
                ramp_cfg <= next_ramp[15:0];
            end else if (wr_cmd) begin
                if (w_strb[0] && w_data[`RSC_CMD_RESTORE_DEF]) begin
                    cfg <= `RSC_CFG_DEFAULT; // see R12
                    ramp_cfg <= `RSC_RAMP_DEFAULT;
                end
                if (w_strb[0] && w_data[`RSC_CMD_STORE_USER]) begin
                    user_cfg <= cfg; // see R13
                    user_ramp <= ramp_cfg;
                end
            end
            if (vin_sample > cfg[`RSC_CFG_ON_LSB +: 8])
                vin_ok <= 1'b1; // see R14
            else if (below_off(vin_sample, cfg[`RSC_CFG_OFF_LSB +: 8]))
                vin_ok <= 1'b0;
            // open pin reads high: negative logic keeps the output off
            conv_on <= init_done && vin_ok && pri_on && sec_on; // see R16, R18
            ctrl_pullup_en <= cfg[`RSC_CFG_SEC_EN] && cfg[`RSC_CFG_SEC_PU]; // see R18
            if (conv_on && vin_ok && below_off(vin_sample, cfg[`RSC_CFG_OFF_LSB +: 8])) begin
                snapshot_store <= 1'b1; // see R20
                snap_count <= snap_count + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // ramp and history capture
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            tick <= 32'h0000_0000;
            due <= 32'h0000_0000;
            state <= ST_WAIT;
            idx <= 5'h00;
            ramp_seen <= 1'b0;
            ramp_failed <= 1'b0;
            busy_d <= 1'b0;
            vendor_status_byte <= 8'h00;
            for (k = 0; k < `RSC_REC_BYTES; k = k + 1)
                ramp_mem[k] <= 8'hFF;
            for (k = 0; k < `RSC_HIST_WORDS; k = k + 1)
                hist_mem[k] <= 16'hFFFF;
        end else begin
            tick <= tick + 32'h0000_0001; // see R21
            busy_d <= ramp_busy;
            if (ramp_start && ramp_seen && ramp_failed)
                vendor_status_byte[`RSC_VSB_RAMP_LOST] <= 1'b1; // see R6
            case (state)
                ST_WAIT: begin
                    if (ramp_start && !ramp_seen) begin
                        ramp_seen <= 1'b1; // see R6
                        {ramp_mem[0], ramp_mem[1]} <= snap_count + 16'h0001; // see R3, R5
                        idx <= 5'h00;
                        // tick moves on every edge: first pair one cycle after the start edge
                        due <= tick + 32'h0000_0001;
                        state <= ST_RAMP;
                    end
                end
                ST_RAMP: begin
                    if (ramp_end) begin
                        hist_mem[0] <= rec_count; // see R9
                        hist_mem[1] <= status_word_in;
                        idx <= 5'h02;
                        due <= tick + HIST_TICKS;
                        state <= ST_HIST;
                        if (ramp_ok) begin
                            for (k = 0; k < `RSC_REC_BYTES; k = k + 1)
                                ramp_mem[k] <= 8'hFF; // see R7
                        end else begin
                            ramp_failed <= 1'b1;
                        end
                    end else if (tick == due && idx < `RSC_PAIRS) begin
                        ramp_mem[{idx[3:0], 1'b0} + 5'h02] <= vin_sample; // see R4
                        ramp_mem[{idx[3:0], 1'b0} + 5'h03] <= vout_sample;
                        idx <= idx + 5'h01; // see R2
                        due <= tick + {16'h0000, interval};
                    end
                end
                ST_HIST: begin
                    if (tick == due) begin
                        hist_mem[idx[3:0]] <= status_word_in; // see R10
                        due <= tick + HIST_TICKS;
                        idx <= idx + 5'h01;
                        // history stops at the last word; it never wraps
                        if (idx == `RSC_HIST_WORDS - 1)
                            state <= ST_DONE;
                    end
                end
                ST_DONE: state <= ST_DONE;
                default: state <= ST_WAIT;
            endcase
        end
    end

endmodule // rsc_recorder

//--- hdl/rsc_defines.vh
// Overview of operation
// R1: ramp record read returns exactly 32 bytes of ramp data.
// R2: during ramp record 15 input/output sample pairs, interval scaled to ramp time.
// R3: record bytes 1 and 2 hold the record counter.
// R4: samples are 8-bit; byte 3 first input, byte 4 first output, alternating.
// R5: counter latched just before ramp as last snapshot count plus one.
// R6: only first ramp per power cycle recorded; later attempt after failure sets bit 6.
// R7: a record reading all FFh means the ramp-up succeeded.
// R8: status history read returns counter word plus 15 status words, 32 bytes.
// R9: history starts after ramp: counter word first, then current status word.
// R10: afterwards one status word appended about every 8 seconds.
// R11: factory default area is write-protected; user area is writable.
// R12: restore-all-defaults copies factory values into the active set.
// R13: active set loaded from user area at init; store-user-all saves it back.
// R14: turn on above on-threshold, off below off-threshold, at least 1 V apart.
// R15: host holds primary on/off pin in new state at least 150 us.
// R16: negative polarity: on only while primary pin tied low, off when open.
// R17: primary on/off pin polarity selectable by configuration.
// R18: secondary pin disabled by default; enable and 3.3 V pull-up selectable.
// R19: secondary pin polarity selectable, positive or negative.
// R20: input loss while converting stores a snapshot and advances snapshot count.
// R21: capture timing derives from a free-running tick counter cleared at init.
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RSC_OFS_CFG 8'h00
`define RSC_OFS_RAMPCFG 8'h04
`define RSC_OFS_CMD 8'h08
`define RSC_OFS_STAT 8'h0C
`define RSC_OFS_SNAP 8'h10
`define RSC_OFS_RAMP_BASE 8'h40
`define RSC_OFS_HIST_BASE 8'h60

// ----------------------------------------
// configuration fields
// ----------------------------------------
`define RSC_CFG_ON_LSB 0
`define RSC_CFG_OFF_LSB 8
`define RSC_CFG_PRI_POS 16
`define RSC_CFG_SEC_EN 17
`define RSC_CFG_SEC_PU 18
`define RSC_CFG_SEC_POS 19
`define RSC_CMD_STORE_USER 0
`define RSC_CMD_RESTORE_DEF 1
`define RSC_VSB_RAMP_LOST 6

// ----------------------------------------
// factory defaults and sizes
// ----------------------------------------
`define RSC_CFG_DEFAULT 32'h0000_5A64
`define RSC_RAMP_DEFAULT 16'h00F0
`define RSC_HYST_CODES 8'h04
`define RSC_REC_BYTES 32
`define RSC_PAIRS 15
`define RSC_HIST_WORDS 16
`define RSC_HIST_SEC 8
`define RSC_CLK_HZ 10000000
`define RSC_HIST_CYC (`RSC_HIST_SEC * `RSC_CLK_HZ)
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2

`endif

//--- verification/rsc_recorder_props.sv
module rsc_recorder_props (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire snapshot_store,
    input wire [7:0] vendor_status_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    write_walk_a: assert property (wr_take |=>
        !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid) else $error("write answer late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    write_busy_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken while answering");
    read_walk_a: assert property (rd_take |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read dropped");
    unmapped_read_a: assert property (rd_take ##0 (s_axi_araddr == 8'h20) |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
    snap_pulse_a: assert property (snapshot_store |=> !snapshot_store)
        else $error("snapshot pulse too long");
    lost_sticky_a: assert property (vendor_status_byte[6] |=> vendor_status_byte[6])
        else $error("ramp lost flag cleared");
endmodule // rsc_recorder_props

//--- verification/rsc_power_stage.sv
module rsc_power_stage (
    input wire aclk,
    input wire conv_on,
    input wire ramp_good,
    output reg ramp_busy = 1'h0,
    output reg ramp_ok = 1'h0,
    output reg [7:0] vout_sample = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [7:0] left = 8'h00;
    reg was_on = 1'h0;
    wire start = conv_on && !was_on;
    wire going = start || left > 8'h01;
    // 40-cycle ramp: long enough for every sample pair at the bench's interval
    always @(posedge aclk) begin
        was_on <= conv_on;
        left <= start ? 8'h28 : (left > 8'h00 ? left - 8'h01 : 8'h00);
        ramp_busy <= going;
        ramp_ok <= ramp_good;
        vout_sample <= going ? 8'h3C : 8'h00;
    end
endmodule // rsc_power_stage

//--- verification/testbench.sv
`define CHK(n, e, g) \
    begin \
        samples_checked = samples_checked + 1; \
        if ((g) !== (e)) begin \
            n_fail = n_fail + 1; \
            $display("unexpected %s expected %h seen %h", n, e, g); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    reg aclk = 1'h0;
    reg aresetn = 1'h0;
    reg [7:0] awaddr = 8'h00;
    reg [7:0] araddr = 8'h00;
    reg [31:0] wdata = 32'h0000_0000;
    reg awvalid = 1'h0;
    reg wvalid = 1'h0;
    reg bready = 1'h0;
    reg arvalid = 1'h0;
    reg rready = 1'h0;
    reg [7:0] vin = 8'h00;
    reg pri = 1'h0;
    reg ctrl = 1'h0;
    reg good = 1'h0;
    wire awready, wready, bvalid, arready, rvalid, busy, ok, on, pu, snap;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] vout, vsb;
    wire [15:0] scnt;
    reg [1:0] rsp;
    reg [31:0] rd;
    reg [41:0] rows [0:9];
    integer n_fail = 0;
    integer samples_checked = 0;
    integer n_snap = 0;
    integer i;

    always #50 aclk = ~aclk;

    // snapshot pulses stand one cycle: count them as they pass
    always @(posedge aclk)
        if (snap === 1'h1) n_snap <= n_snap + 1;

    rsc_recorder #(.HIST_TICKS(32'h0000_0014)) uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .vin_sample(vin), .vout_sample(vout), .ramp_busy(busy), .ramp_ok(ok),
        .status_word_in(16'h1234), .nv_snap_count(16'h0007),
        .primary_on_off_pin(pri), .ctrl_pin(ctrl), .conv_on(on), .ctrl_pullup_en(pu),
        .snapshot_store(snap), .snap_count(scnt), .vendor_status_byte(vsb)
    );
    rsc_power_stage pwr (
        .aclk(aclk), .conv_on(on), .ramp_good(good),
        .ramp_busy(busy), .ramp_ok(ok), .vout_sample(vout)
    );

    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    task stall;
        begin
            n_fail = n_fail + 1;
            end_sim;
        end
    endtask

    // write and read hold each channel until its own ready, then release
    task automatic wr(input [7:0] a, input [31:0] d);
        integer k;
        reg done;
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            done = 1'h0;
            for (k = 0; k < 50 && !done; k = k + 1) begin
                @(posedge aclk);
                if (awready) awvalid <= 1'h0;
                if (wready) wvalid <= 1'h0;
                if (bvalid) begin
                    rsp = bresp;
                    bready <= 1'h0;
                    done = 1'h1;
                end
            end
            if (!done) stall;
        end
    endtask

    task automatic rd8(input [7:0] a);
        integer k;
        reg done;
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            done = 1'h0;
            for (k = 0; k < 50 && !done; k = k + 1) begin
                @(posedge aclk);
                if (arready) arvalid <= 1'h0;
                if (rvalid) begin
                    rd = rdata;
                    rsp = rresp;
                    rready <= 1'h0;
                    done = 1'h1;
                end
            end
            if (!done) stall;
        end
    endtask

    task rst;
        begin
            aresetn <= 1'h0;
            repeat (3) @(posedge aclk);
            aresetn <= 1'h1;
            repeat (2) @(posedge aclk);
        end
    endtask

    // pin changes stand 150 us before the result is judged
    task hold;
        repeat (1500) @(posedge aclk);
    endtask

    task till(input v);
        integer k;
        begin
            for (k = 0; k < 200 && busy !== v; k = k + 1) @(posedge aclk);
            if (busy !== v) stall;
        end
    endtask

    initial begin
        rows[0] = {8'h00, 32'h0000_5A64, 2'h0};
        rows[1] = {8'h04, 32'h0000_00F0, 2'h0};
        rows[2] = {8'h10, 32'h0000_0007, 2'h0};
        rows[3] = {8'h40, 32'hFFFF_FFFF, 2'h0};
        rows[4] = {8'h5C, 32'hFFFF_FFFF, 2'h0};
        rows[5] = {8'h60, 32'hFFFF_FFFF, 2'h0};
        rows[6] = {8'h7C, 32'hFFFF_FFFF, 2'h0};
        rows[7] = {8'h20, 32'h0000_0000, 2'h2};
        rows[8] = {8'h80, 32'h0000_0000, 2'h2};
        rows[9] = {8'h0C, 32'h0000_0002, 2'h0};
        rst;
        for (i = 0; i < 10; i = i + 1) begin
            rd8(rows[i][41:34]);
            `CHK("row data", rows[i][33:2], rd);
            `CHK("row resp", rows[i][1:0], rsp);
        end
        wr(8'h04, 32'h0000_0010);
        vin <= 8'h70;
        till(1'h1);
        till(1'h0);
        rd8(8'h40);
        `CHK("ramp head", 32'h3C70_0800, rd);
        rd8(8'h5C);
        `CHK("ramp tail", 32'h3C70_3C70, rd);
        rd8(8'h60);
        `CHK("hist head", 32'h1234_0008, rd);
        rd8(8'h7C);
        `CHK("hist early", 32'hFFFF_FFFF, rd);
        hold;
        rd8(8'h7C);
        `CHK("hist tail", 32'h1234_1234, rd);
        pri <= 1'h1;
        hold;
        `CHK("open off", 1'h0, on);
        pri <= 1'h0;
        hold;
        `CHK("tied on", 1'h1, on);
        `CHK("lost flag", 1'h1, vsb[6]);
        rd8(8'h40);
        `CHK("ramp kept", 32'h3C70_0800, rd);
        `CHK("pull-up idle", 1'h0, pu);
        wr(8'h00, 32'h0001_5A64);
        hold;
        `CHK("pos off", 1'h0, on);
        pri <= 1'h1;
        hold;
        `CHK("pos on", 1'h1, on);
        wr(8'h00, 32'h000F_5A64);
        hold;
        `CHK("sec off", 1'h0, on);
        `CHK("pull-up", 1'h1, pu);
        ctrl <= 1'h1;
        hold;
        `CHK("sec on", 1'h1, on);
        vin <= 8'h50;
        hold;
        `CHK("snap count", 16'h0008, scnt);
        `CHK("snap pulses", 1, n_snap);
        `CHK("vin low off", 1'h0, on);
        wr(8'h00, 32'h0000_6364);
        `CHK("cfg resp", 2'h0, rsp);
        rd8(8'h00);
        `CHK("off clamp", 32'h0000_6064, rd);
        wr(8'h08, 32'h0000_0002);
        rd8(8'h00);
        `CHK("restore", 32'h0000_5A64, rd);
        wr(8'h0C, 32'h0000_0000);
        `CHK("status ro", 2'h2, rsp);
        wr(8'h40, 32'h0000_0000);
        `CHK("record ro", 2'h2, rsp);
        wr(8'h00, 32'h0000_5A68);
        wr(8'h08, 32'h0000_0001);
        rst;
        rd8(8'h00);
        `CHK("user kept", 32'h0000_5A68, rd);
        pri <= 1'h0;
        good <= 1'h1;
        vin <= 8'h70;
        till(1'h1);
        till(1'h0);
        rd8(8'h40);
        `CHK("ok head", 32'hFFFF_FFFF, rd);
        rd8(8'h5C);
        `CHK("ok tail", 32'hFFFF_FFFF, rd);
        rd8(8'h60);
        `CHK("ok hist", 32'h1234_0008, rd);
        end_sim;
    end
endmodule // testbench

bind rsc_recorder rsc_recorder_props chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .snapshot_store(snapshot_store),
    .vendor_status_byte(vendor_status_byte)
);
